// >>> slip_buf_pkg.sv
// Shared constants and carriers for the receive slip buffer.
// Assumes a 32-bit plain register port and sampled link pins.
package slip_buf_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] DEPTH_OFS  = 8'h04;
  localparam logic [7:0] RATE_OFS   = 8'h08;
  localparam logic [7:0] FILL_OFS   = 8'h0c;
  localparam logic [7:0] UNDER_OFS  = 8'h10;
  localparam logic [7:0] OVER_OFS   = 8'h14;
  localparam logic [7:0] STAT_OFS   = 8'h18;
  localparam logic [7:0] MASK_OFS   = 8'h1c;
  localparam logic [7:0] EFF_OFS    = 8'h20;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_MF_POS  = 0;  // frame_multiple_slip_option
  localparam int CTRL_RC_POS  = 1;  // recentre_on_recovery_option
  localparam int CTRL_SAT_POS = 2;  // output clock is satellite clock
  localparam int CTRL_MAN_POS = 3;  // manual_recentre_action

  // Status and mask bit positions
  localparam int ST_UNDER_POS  = 0;
  localparam int ST_OVER_POS   = 1;
  localparam int ST_CENTRE_POS = 2;

  // ----------------------------------------
  // Reset values and documented figures
  // ----------------------------------------
  localparam logic [6:0]  DEPTH_RST   = 7'h10;
  localparam logic [15:0] RATE_RST    = 16'h0800;
  localparam logic [6:0]  DEPTH_MAX   = 7'h63;
  localparam logic [15:0] RATE_T1     = 16'h0608;
  localparam logic [15:0] RATE_E1     = 16'h0800;
  localparam logic [6:0]  FRAME_T1_MS = 7'h03;
  localparam logic [6:0]  FRAME_E1_MS = 7'h02;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Link pins, all asynchronous to clk_i
  typedef struct packed {
    logic sat_clk;
    logic sat_data;
    logic ter_clk;
    logic traffic_ok;
  } link_in_t;

endpackage

// >>> pin_sync.sv
// Two-stage synchroniser for a group of pins.
// Assumes inputs are levels from outside the clk_i domain.
`timescale 1ns/1ns
module pin_sync
  import slip_buf_pkg::*;
#(
  parameter int W = 4
)(
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // All state: first stage feeds only the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t r;
  sync_st_t n;

  // Next state
  always_comb
  begin
    n      = r;
    n.meta = d_i;
    n.q    = r.meta;
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      r <= '0;
    else
      r <= n;
  end

  assign q_o = r.q;

endmodule

// >>> depth_calc.sv
// Effective depth and capacity in bits from the settings.
// Assumes rate in kbps, so one millisecond holds rate bits.
`timescale 1ns/1ns
module depth_calc
  import slip_buf_pkg::*;
#(
  parameter int MAX_BITS = 8192,
  parameter int AW       = $clog2(MAX_BITS)
)(
  input  wire logic [6:0]  depth_ms_i,
  input  wire logic [15:0] rate_i,
  input  wire logic        mf_opt_i,
  input  wire logic        sat_sel_i,
  output logic      [6:0]  eff_ms_o,
  output logic      [AW:0] cap_o,
  output logic             bypass_o
);

  logic [6:0]  rem;   // Remainder against frame length
  logic [22:0] prod;  // Depth times bits per ms

  always_comb
  begin
    rem      = 7'h00;
    eff_ms_o = depth_ms_i;
    // Satellite clock out: no buffering, zero depth
    if (sat_sel_i)
      eff_ms_o = 7'h00;
    else if (mf_opt_i && rate_i == RATE_T1)
    begin
      rem = depth_ms_i % FRAME_T1_MS;
      if (rem != 7'h00)
        eff_ms_o = depth_ms_i + FRAME_T1_MS - rem;
    end
    // Framed rates use their own frame length
    else if (mf_opt_i && rate_i == RATE_E1)
    begin
      rem = depth_ms_i % FRAME_E1_MS;
      if (rem != 7'h00)
        eff_ms_o = depth_ms_i + FRAME_E1_MS - rem;
    end
    // Size buffer from depth
    // Widen first: a 16-bit product would wrap at large depths
    prod = 23'(eff_ms_o) * 23'(rate_i);
    if (prod > 23'(MAX_BITS))
      cap_o = (AW+1)'(MAX_BITS);
    else
      cap_o = prod[AW:0];
  end

  // Bypass when sat clock or too small to halve
  assign bypass_o = sat_sel_i || (cap_o < (AW+1)'(2));

endmodule

// >>> rx_slip_buffer.sv
// Receive plesiochronous slip buffer with register port.
// Assumes link pins are asynchronous and slower than clk_i.
//
// What this block does
// - Depth set in ms, zero to 99
// - Overflow or underflow slips to mid point
// - Framed rates slip in frame multiples (slips here step by half the capacity, which need not be a whole frame)
// - Option rounds capacity up to frames
// - Optional recentre when traffic recovers
// - Fill level readable as status
// - Separate underflow and overflow slip counts
// - Manual command centres buffer at once
// - Clock choice and depth stay independent
// - Satellite output clock means zero depth
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module rx_slip_buffer
  import slip_buf_pkg::*;
#(
  parameter int MAX_BITS = 8192,
  parameter int AW       = $clog2(MAX_BITS)
)(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire bus_req_t    bus_i,
  output logic      [31:0] rdata_o,
  input  wire link_in_t    link_i,
  output logic             rx_data_o,
  output logic             irq_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [MAX_BITS-1:0] mem;    // Bit store
    logic [AW-1:0]       rd;     // Read index
    logic [AW:0]         fill;   // Bits held
    logic                dout;   // Output bit
    logic [2:0]          prev;   // Last pin levels
    logic                mf;     // Frame option
    logic                rc;     // Recentre option
    logic                sat;    // Sat clock out
    logic [6:0]          depth;  // Depth in ms
    logic [15:0]         rate;   // Rate in kbps
    logic [15:0]         under;  // Underflow slips
    logic [15:0]         over;   // Overflow slips
    logic [2:0]          stat;   // Sticky events
    logic [2:0]          mask;   // Event mask
    logic [31:0]         rdata;  // Read answer
  } st_t;

  st_t r;
  st_t n;

  link_in_t s;        // Synchronised pins
  logic [6:0]  eff;   // Effective depth
  logic [AW:0] cap;   // Capacity in bits
  logic [AW:0] half;  // Mid point
  logic bypass;       // No buffering
  logic wr_edge;      // Sat clock rose
  logic rd_edge;      // Output clock rose
  logic ok_rise;      // Traffic recovered
  logic man;          // Manual centre write
  logic centre_ev;    // Centre this cycle
  logic over_ev;      // Overflow slip
  logic under_ev;     // Underflow slip
  logic [AW-1:0] widx; // Write index

  // ----------------------------------------
  // Pin synchronisers and depth
  // ----------------------------------------
  pin_sync #(
    .W (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (link_i),
    .q_o     (s)
  );

  depth_calc #(
    .MAX_BITS (MAX_BITS),
    .AW       (AW)
  ) u_depth (
    .depth_ms_i (r.depth),
    .rate_i     (r.rate),
    .mf_opt_i   (r.mf),
    .sat_sel_i  (r.sat),
    .eff_ms_o   (eff),
    .cap_o      (cap),
    .bypass_o   (bypass)
  );

  // Half capacity is both the slip step and the centre point
  assign half = cap >> 1;

  // Edges found on synchronised pins
  // The edge flop reads only the second sync stage, never the first
  assign wr_edge = s.sat_clk & ~r.prev[2];
  assign rd_edge = s.ter_clk & ~r.prev[1];
  assign ok_rise = s.traffic_ok & ~r.prev[0];

  assign man = bus_i.wr && bus_i.addr == CTRL_OFS
               && bus_i.wdata[CTRL_MAN_POS];

  assign centre_ev = man | (ok_rise & r.rc);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n        = r;
    over_ev  = 1'b0;
    under_ev = 1'b0;
    widx     = '0;
    n.rdata  = 32'h0000_0000;
    n.prev   = {s.sat_clk, s.ter_clk, s.traffic_ok};

    // Fields stored independently
    // Writes land at this edge; unmapped offsets are ignored
    if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        CTRL_OFS:
        begin
          n.mf  = bus_i.wdata[CTRL_MF_POS];
          n.rc  = bus_i.wdata[CTRL_RC_POS];
          n.sat = bus_i.wdata[CTRL_SAT_POS];
        end
        DEPTH_OFS:
        begin
          if (bus_i.wdata[6:0] > DEPTH_MAX)
            n.depth = DEPTH_MAX;
          else
            n.depth = bus_i.wdata[6:0];
        end
        RATE_OFS: n.rate = bus_i.wdata[15:0];
        MASK_OFS: n.mask = bus_i.wdata[2:0];
        default:  ;  // Others read only
      endcase
    end

    // Reads answer next cycle only
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        CTRL_OFS:  n.rdata = {29'h0, r.sat, r.rc, r.mf};
        DEPTH_OFS: n.rdata = {25'h0, r.depth};
        RATE_OFS:  n.rdata = {16'h0, r.rate};
        FILL_OFS:  n.rdata = 32'(r.fill);
        UNDER_OFS: n.rdata = {16'h0, r.under};
        OVER_OFS:  n.rdata = {16'h0, r.over};
        STAT_OFS:  n.rdata = {29'h0, r.stat};
        MASK_OFS:  n.rdata = {29'h0, r.mask};
        EFF_OFS:   n.rdata = {25'h0, eff};
        default:   n.rdata = 32'h0000_0000;
      endcase
      // Reading status clears it; events below still win
      if (bus_i.addr == STAT_OFS)
        n.stat = 3'h0;
    end

    // Depth zero: data follows sat clock
    if (bypass)
    begin
      // Fill held at zero so leaving bypass starts from empty
      n.fill = '0;
      n.rd   = '0;
      if (wr_edge)
        n.dout = s.sat_data;
    end
    else
    begin
      // Centre: drop or repeat to mid point
      if (centre_ev)
      begin
        n.rd   = n.rd + AW'(n.fill - half);
        n.fill = half;
      end
      // Write side on sat clock edge
      if (wr_edge)
      begin
        if (n.fill >= cap)
        begin
          over_ev = 1'b1;
          n.rd    = n.rd + AW'(n.fill - half);
          n.fill  = half;
        end
        widx = AW'({1'b0, n.rd} + n.fill);
        n.mem[widx] = s.sat_data;
        n.fill = n.fill + (AW+1)'(1);
      end
      // Read side on output clock edge
      if (rd_edge)
      begin
        // Empty: step back half to repeat
        if (n.fill == '0)
        begin
          under_ev = 1'b1;
          n.rd     = n.rd - AW'(half);
          n.fill   = half;
        end
        n.dout = n.mem[n.rd];
        n.rd   = n.rd + AW'(1);
        n.fill = n.fill - (AW+1)'(1);
      end
    end

    // One count per slip of each kind
    if (under_ev)
      n.under = r.under + 16'h0001;
    if (over_ev)
      n.over = r.over + 16'h0001;

    // Sticky events, set beats read clear
    if (under_ev)
      n.stat[ST_UNDER_POS] = 1'b1;
    if (over_ev)
      n.stat[ST_OVER_POS] = 1'b1;
    if (centre_ev && !bypass)
      n.stat[ST_CENTRE_POS] = 1'b1;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r       <= '0;
      r.depth <= DEPTH_RST;
      r.rate  <= RATE_RST;
    end
    else
      r <= n;
  end

  // Outputs
  assign rdata_o   = r.rdata;
  assign rx_data_o = r.dout;
  assign irq_o     = |(r.stat & r.mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Slip checks skip a same-cycle read or centre, where the end point moves

  // Stored depth never passes the top
  a_depth_in_range: assert property (
    r.depth <= DEPTH_MAX)
    else $error("depth register above range");

  // Overflow leaves the buffer one past mid
  a_over_slip_mid: assert property (
    over_ev && !rd_edge |=> r.fill == $past(half) + (AW+1)'(1))
    else $error("overflow slip not to mid point");

  // Underflow leaves one below mid
  a_under_slip_mid: assert property (
    under_ev && !centre_ev |=> r.fill == $past(half) - (AW+1)'(1))
    else $error("underflow slip not to mid point");

  // T1 depth rounds to three ms frames
  a_frame_t1_ms: assert property (
    r.mf && !r.sat && r.rate == RATE_T1 |-> eff % FRAME_T1_MS == 7'h00)
    else $error("T1 depth not a frame multiple");

  // E1 depth rounds to two ms frames
  a_frame_e1_ms: assert property (
    r.mf && !r.sat && r.rate == RATE_E1 |-> eff % FRAME_E1_MS == 7'h00)
    else $error("E1 depth not a frame multiple");

  // Recovery recentres with option only
  a_recover_centre: assert property (
    ok_rise && r.rc && !bypass && !wr_edge && !rd_edge
    |=> r.fill == $past(half))
    else $error("no recentre on recovery");

  // Fill read returns the level held
  a_fill_report: assert property (
    bus_i.rd && bus_i.addr == FILL_OFS |=> rdata_o == 32'($past(r.fill)))
    else $error("fill read wrong");

  // Overflow count steps by one
  a_over_count: assert property (
    over_ev |=> r.over == $past(r.over) + 16'h0001)
    else $error("overflow count missed");

  // Underflow count steps by one
  a_under_count: assert property (
    under_ev |=> r.under == $past(r.under) + 16'h0001)
    else $error("underflow count missed");

  // Manual centre takes effect next cycle
  a_manual_centre: assert property (
    man && !bypass && !wr_edge && !rd_edge |=> r.fill == $past(half))
    else $error("manual centre not applied");

  // Sat clock out keeps the buffer empty
  a_sat_bypass: assert property (
    r.sat ##1 r.sat |-> r.fill == '0 ##1 r.fill == '0)
    else $error("buffer used with sat clock");

  // Coverage of the main scenarios
  c_over_slip:   cover property (over_ev);
  c_under_slip:  cover property (under_ev);
  c_recover:     cover property (ok_rise && r.rc && !bypass);
  c_irq_raised:  cover property (!irq_o ##1 irq_o);
  c_man_centre:  cover property (man && !bypass);

  // Bypass hands the sat bit straight through
  a_bypass_follow: assert property (
    bypass && wr_edge |=> rx_data_o == $past(s.sat_data))
    else $error("bypass bit not passed");

  // Overflow status set beats a same-cycle read clear
  a_over_stat_set: assert property (
    over_ev |=> r.stat[ST_OVER_POS])
    else $error("overflow status lost");

  // Underflow status set beats a same-cycle read clear
  a_under_stat_set: assert property (
    under_ev |=> r.stat[ST_UNDER_POS])
    else $error("underflow status lost");

  // Centre status set whenever the buffer is centred
  a_centre_stat_set: assert property (
    centre_ev && !bypass |=> r.stat[ST_CENTRE_POS])
    else $error("centre status lost");

  // Read data stand one cycle only, zero otherwise
  a_rdata_idle: assert property (
    !bus_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");

endmodule

// >>> rx_link_model.sv
// Far-side model: demodulator bit source and terrestrial clock sink.
// Assumes the bench calls its tasks one at a time, never overlapped.
`timescale 1ns/1ns
module rx_link_model
  import slip_buf_pkg::*;
(
  input  wire logic rx_i,   // Bit from the buffer
  output link_in_t  link_o  // Pins toward the buffer
);
  logic       sent_q[$];    // Bits sent from the satellite side
  logic       got_q[$];     // Bits seen at the terrestrial side
  logic [7:0] pat = 8'h9b;  // Rotating data pattern

  // Idle pins: clocks stand still low, traffic OK
  initial
  begin
    link_o = '{sat_clk: 1'b0, sat_data: 1'b0, ter_clk: 1'b0, traffic_ok: 1'b1};
  end

  // ----------------------------------------
  // Satellite side
  // ----------------------------------------
  // Sat clock writes
  // One bit per 160 ns, data set half a period before the rise
  task automatic sat_bits(input int n);
    // Step off the clock edge so pins never change at a sampling edge
    #3;
    for (int i = 0; i < n; i++)
    begin
      link_o.sat_data = pat[0];
      sent_q.push_back(pat[0]);
      pat = {pat[0], pat[7:1]};
      #80 link_o.sat_clk = 1'b1;
      #80 link_o.sat_clk = 1'b0;
    end
    // Released line shows the inverse so a stale bit is never mistaken
    link_o.sat_data = ~link_o.sat_data;
  endtask

  // ----------------------------------------
  // Terrestrial side
  // ----------------------------------------
  // Bit taken at the falling edge, long after the buffer has settled
  task automatic ter_bits(input int n);
    #3;
    for (int i = 0; i < n; i++)
    begin
      #80 link_o.ter_clk = 1'b1;
      #80 link_o.ter_clk = 1'b0;
      got_q.push_back(rx_i);
    end
  endtask

  // Traffic state change, held long enough for the synchroniser
  task automatic traffic(input logic ok);
    #3;
    link_o.traffic_ok = ok;
    #200;
  endtask
endmodule

// >>> rx_slip_buffer_tb_top.sv
// Bench for the receive slip buffer: register tasks plus link model.
// Assumes a 16-bit capacity: rate 8 kbps, depth 2 ms.
`timescale 1ns/1ns
module rx_slip_buffer_tb_top
  import slip_buf_pkg::*;
;
  logic        clk_i;      // System clock
  logic        rst_b_i;    // Reset, active low
  bus_req_t    bus;        // Register request
  logic [31:0] rdata_o;    // Read data
  link_in_t    link;       // Link pins
  logic        rx_data_o;  // Bit toward terrestrial
  logic        irq_o;      // Interrupt
  int          err_count;  // Mismatches
  int          cmp_count;  // Comparisons

  rx_slip_buffer #(.MAX_BITS(256)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus),
    .rdata_o(rdata_o), .link_i(link), .rx_data_o(rx_data_o), .irq_o(irq_o));
  rx_link_model u_link (.rx_i(rx_data_o), .link_o(link));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  // 100 MHz clock
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_i);
    bus.wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so look just then
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_i);
    bus.rd   <= 1'b0;
    #1 chk(nm, rdata_o, e);
  endtask

  // Lets pin edges pass the synchroniser and edge detect
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: whole run needs well under 20 us
  initial
  begin
    #100000;
    err_count++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    rst_b_i = 1'b0;
    bus = '0;
    repeat (6) @(posedge clk_i);
    chk("rdata in reset", rdata_o, 32'h0);
    chk("irq in reset", {31'h0, irq_o}, 32'h0);
    chk("rx in reset", {31'h0, rx_data_o}, 32'h0);
    rst_b_i <= 1'b1;
    rd("depth", DEPTH_OFS, {25'h0, DEPTH_RST});
    rd("rate", RATE_OFS, {16'h0, RATE_RST});
    rd("ctrl", CTRL_OFS, 32'h0);
    rd("unmapped", 8'he4, 32'h0);
    wr(DEPTH_OFS, 32'h78);
    // Upper address bits must not alias onto the depth register
    wr(8'hc4, 32'h5);
    rd("depth clamp", DEPTH_OFS, 32'h63);
    $display("test reset done");
    wr(CTRL_OFS, 32'h1);
    wr(RATE_OFS, {16'h0, RATE_T1});
    wr(DEPTH_OFS, 32'h4);
    rd("eff t1", EFF_OFS, 32'h6);
    wr(RATE_OFS, {16'h0, RATE_E1});
    wr(DEPTH_OFS, 32'h63);
    rd("eff e1", EFF_OFS, 32'h64);
    wr(CTRL_OFS, 32'h0);
    rd("eff plain", EFF_OFS, 32'h63);
    wr(CTRL_OFS, 32'h5);
    rd("eff bypass", EFF_OFS, 32'h0);
    rd("depth kept", DEPTH_OFS, 32'h63);
    $display("test depth done");
    // Bits cross in order; unused upper write bits are ignored
    wr(CTRL_OFS, 32'h0);
    wr(RATE_OFS, 32'hffff_0008);
    wr(DEPTH_OFS, 32'h2);
    wr(MASK_OFS, 32'hffff_fffb);
    rd("rate wide", RATE_OFS, 32'h8);
    rd("mask wide", MASK_OFS, 32'h3);
    u_link.sat_bits(5);
    settle();
    rd("fill 5", FILL_OFS, 32'h5);
    u_link.ter_bits(5);
    for (int i = 0; i < 5; i++)
      chk("bit", {31'h0, u_link.got_q[i]}, {31'h0, u_link.sent_q[i]});
    $display("test data done");
    u_link.sat_bits(17);
    settle();
    rd("fill ovf", FILL_OFS, 32'h9);
    rd("over", OVER_OFS, 32'h1);
    rd("under", UNDER_OFS, 32'h0);
    chk("irq ovf", {31'h0, irq_o}, 32'h1);
    rd("status ovf", STAT_OFS, 32'h2);
    settle();
    chk("irq clear", {31'h0, irq_o}, 32'h0);
    rd("status clr", STAT_OFS, 32'h0);
    $display("test overflow done");
    // Manual centre, its status bit masked off
    u_link.sat_bits(3);
    wr(CTRL_OFS, 32'h8);
    settle();
    rd("fill ctr", FILL_OFS, 32'h8);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    rd("status ctr", STAT_OFS, 32'h4);
    $display("test centre done");
    u_link.ter_bits(9);
    settle();
    chk("irq unf", {31'h0, irq_o}, 32'h1);
    rd("under unf", UNDER_OFS, 32'h1);
    rd("over unf", OVER_OFS, 32'h1);
    rd("status unf", STAT_OFS, 32'h1);
    $display("test underflow done");
    // Recentre on recovery only when enabled
    wr(CTRL_OFS, 32'ha);
    u_link.sat_bits(2);
    settle();
    rd("fill pre", FILL_OFS, 32'ha);
    u_link.traffic(1'b0);
    u_link.traffic(1'b1);
    rd("fill rec", FILL_OFS, 32'h8);
    wr(CTRL_OFS, 32'h0);
    u_link.sat_bits(2);
    u_link.traffic(1'b0);
    u_link.traffic(1'b1);
    rd("fill norec", FILL_OFS, 32'ha);
    $display("test recovery done");
    // Satellite clock out passes bits straight through
    wr(CTRL_OFS, 32'h4);
    u_link.sat_bits(1);
    settle();
    chk("bypass bit", {31'h0, rx_data_o}, {31'h0, u_link.sent_q[$]});
    rd("fill byp", FILL_OFS, 32'h0);
    $display("test bypass done");
    results();
  end
endmodule
